// ### design/tpgdc_top.sv
/*
 * Gate drive control logic for three half-bridges with an AHB-Lite
 * register slave.  Assumes command, comparator and fault inputs are
 * synchronous to clock, and that the analog drivers act on the
 * peak, strong-sink, hold and high-impedance strobes given here.
 */
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// Function
// - each gate command picks one of six control inputs by select field
// - mode 0: high command drives high gate, low command drives low gate
// - mode 0: both commands equal means both gates off, one turns its own
// - mode 1: low command enables bridge, high command switches it
// - mode 1: enable low forces both off; else control picks the gate
// - sixteen source strength levels, separate for high and low drivers
// - sink strength is always twice the source strength setting
// - two-bit field picks one of four maximum transition times
// - complement gate sinks strongly during a transition, at most that time
// - after the transition a weak hold pull-up or pull-down takes over
// - adaptive mode waits for the off gate comparator before turn-on
// - configurable extra dead time is added before complement turn-on
// - turn-off peak and strong sink end at the below-threshold report
// - turn-on peak and strong sink last the full transition time
// - adaptive disable ignores the comparator, command alone governs
// - adaptive disabled: dead time starts at the command rise
// - adaptive disabled: peak current always lasts the full time
// - a late command adds its own gap to the dead time
// - an early command is held until adaptive plus extra dead time
// - adaptive disabled: dead time is command gap plus extra time
// - a fault blocks commands and holds gates high impedance pulled down
// - fault clears only by clear bit write or enable pulled low
module tpgdc_top
    import tpgdc_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic operating_mode,
    input wire logic enable_in,
    input wire logic fault_in,
    input wire logic [NIN-1:0] control_input_n,
    input wire logic [NPH-1:0] high_gate_below,
    input wire logic [NPH-1:0] low_gate_below,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DW-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [DW-1:0] hrdata,
    output logic [NPH-1:0] high_gate_out,
    output logic [NPH-1:0] low_gate_out,
    output logic [NPH-1:0] high_peak,
    output logic [NPH-1:0] low_peak,
    output logic [NPH-1:0] high_strong_sink,
    output logic [NPH-1:0] low_strong_sink,
    output logic [NPH-1:0] high_hold_pullup,
    output logic [NPH-1:0] high_hold_pulldown,
    output logic [NPH-1:0] low_hold_pullup,
    output logic [NPH-1:0] low_hold_pulldown,
    output logic gate_hiz_pulldown,
    output logic [STR_W-1:0] high_source_strength,
    output logic [STR_W:0] high_sink_strength,
    output logic [STR_W-1:0] low_source_strength,
    output logic [STR_W:0] low_sink_strength,
    output logic fault_out_n
);

    tpgdc_state_t s;
    tpgdc_state_t n;
    logic [NPH-1:0] hi_cmd;
    logic [NPH-1:0] lo_cmd;
    logic [NPH-1:0] want_h;
    logic [NPH-1:0] want_l;
    logic addr_ph;
    logic clr;
    logic blocked;

    // unused select codes read as a low command
    function automatic logic pick(input logic [NIN-1:0] in,
                                  input logic [SEL_W-1:0] sel);
        pick = 1'b0;
        for (int i = 0; i < NIN; i++)
        begin
            if (sel == SEL_W'(i))
                pick = in[i];
        end
    endfunction

    // ==========================================================
    // command selection and mode decode
    for (genvar p = 0; p < NPH; p++)
    begin : g_ph
        assign hi_cmd[p] = pick(control_input_n,
                                s.sel[p*SEL_W +: SEL_W]);
        assign lo_cmd[p] = pick(control_input_n,
                                s.sel[LOW_SEL_LSB + p*SEL_W +: SEL_W]);
        assign want_h[p] = s.mode ? (lo_cmd[p] & hi_cmd[p])
                                  : (hi_cmd[p] & ~lo_cmd[p]);
        assign want_l[p] = s.mode ? (lo_cmd[p] & ~hi_cmd[p])
                                  : (lo_cmd[p] & ~hi_cmd[p]);
    end

    assign addr_ph = hsel & htrans[HTRANS_ACT_BIT] & hready;

    // ==========================================================
    // next state
    always_comb
    begin
        n = s;
        clr = 1'b0;
        if (s.wr_pend)
        begin
            case (s.wr_addr)
                REG_CTRL:
                begin
                    n.mode = hwdata[CTRL_MODE_BIT];
                    n.adt_dis = hwdata[CTRL_ADT_DIS_BIT];
                    n.gt_sel = hwdata[CTRL_GT_LSB +: 2];
                    n.dt_sel = hwdata[CTRL_DT_LSB +: 2];
                    clr = hwdata[CTRL_CLR_BIT];
                end
                REG_SEL:
                    n.sel = hwdata[SEL_TOT_W-1:0];
                REG_DRIVE:
                begin
                    n.hs_str = hwdata[DRV_HS_LSB +: STR_W];
                    n.ls_str = hwdata[DRV_LS_LSB +: STR_W];
                end
                default:
                    n.sel = n.sel;
            endcase
        end
        n.wr_pend = addr_ph & hwrite;
        n.wr_addr = haddr[AW-1:0];

        // a new fault wins over a clear in the same cycle
        n.fault = fault_in | (s.fault & ~clr & enable_in);
        // blocked commands force every phase off
        blocked = ~operating_mode | fault_in | s.fault;

        for (int p = 0; p < NPH; p++)
        begin
            if (blocked)
            begin
                n.ph[p] = PH_OFF;
                n.hg[p] = 1'b0;
                n.lg[p] = 1'b0;
                n.trans[p] = 1'b0;
            end
            else
            begin
                if (s.trans[p])
                begin
                    if (s.tcnt[p] == '0)
                        n.trans[p] = 1'b0;
                    // turn-off ends early on the comparator report
                    else if (!s.trans_on[p] && !s.adt_dis
                             && (s.trans_hs[p] ? high_gate_below[p]
                                               : low_gate_below[p]))
                        n.trans[p] = 1'b0;
                    else
                        n.tcnt[p] = s.tcnt[p] - 1'b1;
                end
                case (s.ph[p])
                    PH_OFF:
                    begin
                        // dead time starts
                        // once the command wants a gate and the other
                        // gate is reported off or the report is ignored
                        if (want_h[p] && (s.adt_dis || low_gate_below[p]))
                        begin
                            n.ph[p] = PH_DEAD_H;
                            n.dcnt[p] = DT_LOAD[s.dt_sel];
                        end
                        else if (want_l[p]
                                 && (s.adt_dis || high_gate_below[p]))
                        begin
                            n.ph[p] = PH_DEAD_L;
                            n.dcnt[p] = DT_LOAD[s.dt_sel];
                        end
                    end
                    PH_DEAD_H:
                    begin
                        if (!want_h[p])
                            n.ph[p] = PH_OFF;
                        else if (s.dcnt[p] == '0)
                        begin
                            n.ph[p] = PH_HIGH;
                            n.hg[p] = 1'b1;
                            n.trans[p] = 1'b1;
                            n.trans_hs[p] = 1'b1;
                            n.trans_on[p] = 1'b1;
                            n.tcnt[p] = GT_LOAD[s.gt_sel];
                        end
                        else
                            n.dcnt[p] = s.dcnt[p] - 1'b1;
                    end
                    PH_DEAD_L:
                    begin
                        if (!want_l[p])
                            n.ph[p] = PH_OFF;
                        else if (s.dcnt[p] == '0)
                        begin
                            n.ph[p] = PH_LOW;
                            n.lg[p] = 1'b1;
                            n.trans[p] = 1'b1;
                            n.trans_hs[p] = 1'b0;
                            n.trans_on[p] = 1'b1;
                            n.tcnt[p] = GT_LOAD[s.gt_sel];
                        end
                        else
                            n.dcnt[p] = s.dcnt[p] - 1'b1;
                    end
                    PH_HIGH:
                    begin
                        if (!want_h[p])
                        begin
                            n.ph[p] = PH_OFF;
                            n.hg[p] = 1'b0;
                            n.trans[p] = 1'b1;
                            n.trans_hs[p] = 1'b1;
                            n.trans_on[p] = 1'b0;
                            n.tcnt[p] = GT_LOAD[s.gt_sel];
                        end
                    end
                    PH_LOW:
                    begin
                        if (!want_l[p])
                        begin
                            n.ph[p] = PH_OFF;
                            n.lg[p] = 1'b0;
                            n.trans[p] = 1'b1;
                            n.trans_hs[p] = 1'b0;
                            n.trans_on[p] = 1'b0;
                            n.tcnt[p] = GT_LOAD[s.gt_sel];
                        end
                    end
                    default:
                        n.ph[p] = PH_OFF;
                endcase
            end
        end

        // read data follows any write landing this cycle
        if (addr_ph && !hwrite)
        begin
            n.rdata = '0;
            case (haddr[AW-1:0])
                REG_CTRL:
                begin
                    n.rdata[CTRL_MODE_BIT] = n.mode;
                    n.rdata[CTRL_ADT_DIS_BIT] = n.adt_dis;
                    n.rdata[CTRL_GT_LSB +: 2] = n.gt_sel;
                    n.rdata[CTRL_DT_LSB +: 2] = n.dt_sel;
                end
                REG_SEL:
                    n.rdata[SEL_TOT_W-1:0] = n.sel;
                REG_DRIVE:
                begin
                    n.rdata[DRV_HS_LSB +: STR_W] = n.hs_str;
                    n.rdata[DRV_LS_LSB +: STR_W] = n.ls_str;
                end
                REG_STATUS:
                begin
                    n.rdata[ST_HG_LSB +: NPH] = s.hg;
                    n.rdata[ST_LG_LSB +: NPH] = s.lg;
                    n.rdata[ST_FLT_BIT] = s.fault;
                    n.rdata[ST_OP_BIT] = operating_mode;
                end
                default:
                    n.rdata = '0;
            endcase
        end
    end

    // ==========================================================
    // state register; reset is not held off by the clock enable
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            s <= '0;
            s.sel <= SEL_RST;
        end
        else if (ce)
            s <= n;
    end

    // ==========================================================
    // outputs
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign hrdata = s.rdata;
    assign high_gate_out = s.hg;
    assign low_gate_out = s.lg;
    assign high_peak = s.trans & s.trans_hs;
    assign low_peak = s.trans & ~s.trans_hs;
    // strong sink on the gate opposite the transition
    assign high_strong_sink = s.trans & ~s.trans_hs;
    assign low_strong_sink = s.trans & s.trans_hs;
    // weak hold once no strong current is applied
    assign high_hold_pullup = s.hg & ~high_peak;
    assign high_hold_pulldown = ~s.hg & ~high_peak & ~high_strong_sink
                                & {NPH{~s.fault}};
    assign low_hold_pullup = s.lg & ~low_peak;
    assign low_hold_pulldown = ~s.lg & ~low_peak & ~low_strong_sink
                               & {NPH{~s.fault}};
    // fault state holds the gates high impedance pulled down
    assign gate_hiz_pulldown = s.fault;
    // source codes and doubled sink codes
    assign high_source_strength = s.hs_str;
    assign high_sink_strength = {s.hs_str, 1'b0};
    assign low_source_strength = s.ls_str;
    assign low_sink_strength = {s.ls_str, 1'b0};
    assign fault_out_n = ~s.fault;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    a_idle_gates_low: assert property (
        (ce && !operating_mode) |=> (high_gate_out == '0
                                     && low_gate_out == '0))
        else $error("gate on outside operating mode");

    a_fault_blocks_gates: assert property (
        (ce && fault_in) |=> (high_gate_out == '0 && low_gate_out == '0
                              && gate_hiz_pulldown))
        else $error("gate on during fault");

    a_fault_sticks: assert property (
        (ce && !fault_out_n && enable_in && !s.wr_pend)
            |=> !fault_out_n)
        else $error("fault released without clear");

    a_no_overlap: assert property (
        (high_gate_out & low_gate_out) == '0)
        else $error("both gates of a phase on");

    a_both_cmd_off: assert property (
        (ce && !s.mode && hi_cmd[0] && lo_cmd[0])
            |=> !high_gate_out[0] && !low_gate_out[0])
        else $error("equal commands left a gate on");

    a_pwm_disable_off: assert property (
        (ce && s.mode && !lo_cmd[0])
            |=> !high_gate_out[0] && !low_gate_out[0])
        else $error("disabled bridge left a gate on");

    a_turnon_peak: assert property (
        $rose(high_gate_out[0]) |-> high_peak[0] && low_strong_sink[0])
        else $error("turn-on without peak and strong sink");

    a_hold_after: assert property (
        (high_gate_out[0] && !high_peak[0])
            |-> high_hold_pullup[0] && !high_hold_pulldown[0])
        else $error("no hold pull-up after transition");

    a_dead_gap: assert property (
        $rose(low_gate_out[0]) |-> !$past(high_gate_out[0], 2))
        else $error("complement turned on without dead time");

    cover property (ce && $rose(high_gate_out[0]));
    cover property (ce && $fell(high_peak[0]) && !high_gate_out[0]);
    cover property (ce && s.mode && $rose(low_gate_out[1]));
    cover property ($fell(fault_out_n));

endmodule

// ### shared/tpgdc_pkg.sv
/*
 * Constants and types of the three-phase gate drive control block:
 * register map, field layout, timing tables and the state record.
 * Assumes a 250 MHz clock; all counts below derive from that period.
 */
package tpgdc_pkg;

    // ==========================================================
    // clock and sizes
    localparam int CLK_PERIOD_NS = 4;
    localparam int NPH = 3;
    localparam int NIN = 6;
    localparam int SEL_W = 3;
    localparam int SEL_TOT_W = 2 * NPH * SEL_W;
    localparam int LOW_SEL_LSB = NPH * SEL_W;
    localparam int STR_W = 4;
    localparam int CNT_W = 10;
    localparam int AW = 8;
    localparam int DW = 32;

    // ==========================================================
    // register byte addresses
    localparam logic [AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AW-1:0] REG_SEL = 8'h04;
    localparam logic [AW-1:0] REG_DRIVE = 8'h08;
    localparam logic [AW-1:0] REG_STATUS = 8'h0C;

    // ==========================================================
    // field positions and reset values
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_ADT_DIS_BIT = 1;
    localparam int CTRL_GT_LSB = 2;
    localparam int CTRL_DT_LSB = 4;
    localparam int CTRL_CLR_BIT = 8;
    localparam int DRV_HS_LSB = 0;
    localparam int DRV_LS_LSB = 4;
    localparam int ST_HG_LSB = 0;
    localparam int ST_LG_LSB = 3;
    localparam int ST_FLT_BIT = 8;
    localparam int ST_OP_BIT = 9;
    // high a,b,c from inputs 0,2,4; low a,b,c from inputs 1,3,5
    localparam logic [SEL_TOT_W-1:0] SEL_RST = 18'h2B310;
    localparam int HTRANS_ACT_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;

    // ==========================================================
    // timing: transition time rounds down, dead time rounds up;
    // the loads are one less because the zero count is a cycle too
    localparam int GT_NS [4] = '{500, 1000, 2000, 4000};
    localparam int DT_NS [4] = '{50, 100, 200, 400};
    localparam logic [CNT_W-1:0] GT_LOAD [4] = '{
        CNT_W'(GT_NS[0] / CLK_PERIOD_NS - 1),
        CNT_W'(GT_NS[1] / CLK_PERIOD_NS - 1),
        CNT_W'(GT_NS[2] / CLK_PERIOD_NS - 1),
        CNT_W'(GT_NS[3] / CLK_PERIOD_NS - 1)};
    localparam logic [CNT_W-1:0] DT_LOAD [4] = '{
        CNT_W'((DT_NS[0] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1),
        CNT_W'((DT_NS[1] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1),
        CNT_W'((DT_NS[2] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1),
        CNT_W'((DT_NS[3] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1)};

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        PH_OFF,
        PH_DEAD_H,
        PH_DEAD_L,
        PH_HIGH,
        PH_LOW
    } tpgdc_phase_t;

    typedef struct packed {
        logic mode;
        logic adt_dis;
        logic [1:0] gt_sel;
        logic [1:0] dt_sel;
        logic [SEL_TOT_W-1:0] sel;
        logic [STR_W-1:0] hs_str;
        logic [STR_W-1:0] ls_str;
        logic fault;
        logic wr_pend;
        logic [AW-1:0] wr_addr;
        logic [DW-1:0] rdata;
        tpgdc_phase_t [NPH-1:0] ph;
        logic [NPH-1:0] hg;
        logic [NPH-1:0] lg;
        logic [NPH-1:0] trans;
        logic [NPH-1:0] trans_hs;
        logic [NPH-1:0] trans_on;
        logic [NPH-1:0][CNT_W-1:0] tcnt;
        logic [NPH-1:0][CNT_W-1:0] dcnt;
    } tpgdc_state_t;

endpackage

// ### testbench/tpgdc_bridge_model.sv
/*
 * Behavioural model of the external half-bridges: each gate sinks
 * below the comparator threshold a few cycles after its drive ends.
 * Assumes gate commands are registered on the same clock.
 */
`timescale 1ns/1ps
module tpgdc_bridge_model
    import tpgdc_pkg::*;
#(
    parameter int DCHG = 3
)
(
    input wire logic clock,
    input wire logic stuck,
    input wire logic [NPH-1:0] high_gate_out,
    input wire logic [NPH-1:0] low_gate_out,
    output logic [NPH-1:0] high_gate_below,
    output logic [NPH-1:0] low_gate_below
);
    int hoff [NPH];
    int loff [NPH];

    // ==========================================================
    // gate discharge
    // a gate is never below at once: real charge takes time to drain
    always @(posedge clock)
    begin
        for (int i = 0; i < NPH; i++)
        begin
            hoff[i] <= high_gate_out[i] ? 0 : hoff[i] + 1;
            loff[i] <= low_gate_out[i] ? 0 : loff[i] + 1;
        end
    end

    // stuck models a dead gate sense that never reports below
    always_comb
    begin
        for (int i = 0; i < NPH; i++)
        begin
            high_gate_below[i] = !stuck && hoff[i] >= DCHG;
            low_gate_below[i] = !stuck && loff[i] >= DCHG;
        end
    end
endmodule

// ### testbench/tpgdc_test.sv
/*
 * Self-checking bench of the gate drive control: registers over
 * AHB-Lite, gate tables, dead and transition timing, fault latch.
 * Assumes the bridge model drives the gate comparators.
 */
`timescale 1ns/1ps
module tpgdc_test
    import tpgdc_pkg::*;
;
    logic clock = 1'h0;
    logic rstn, ce, operating_mode, enable_in, fault_in, stuck;
    logic [NIN-1:0] control_input_n;
    logic [NPH-1:0] high_gate_below, low_gate_below;
    logic hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [DW-1:0] hwdata, hrdata;
    logic [NPH-1:0] high_gate_out, low_gate_out, high_peak, low_peak;
    logic [NPH-1:0] high_strong_sink, low_strong_sink;
    logic [NPH-1:0] high_hold_pullup, high_hold_pulldown;
    logic [NPH-1:0] low_hold_pullup, low_hold_pulldown;
    logic gate_hiz_pulldown, fault_out_n;
    logic [STR_W-1:0] high_source_strength, low_source_strength;
    logic [STR_W:0] high_sink_strength, low_sink_strength;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    int n;

    tpgdc_top u_tpgdc_top (.clock(clock), .rstn(rstn), .ce(ce),
        .operating_mode(operating_mode), .enable_in(enable_in),
        .fault_in(fault_in), .control_input_n(control_input_n),
        .high_gate_below(high_gate_below), .low_gate_below(low_gate_below),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .high_gate_out(high_gate_out), .low_gate_out(low_gate_out),
        .high_peak(high_peak), .low_peak(low_peak),
        .high_strong_sink(high_strong_sink),
        .low_strong_sink(low_strong_sink),
        .high_hold_pullup(high_hold_pullup),
        .high_hold_pulldown(high_hold_pulldown),
        .low_hold_pullup(low_hold_pullup),
        .low_hold_pulldown(low_hold_pulldown),
        .gate_hiz_pulldown(gate_hiz_pulldown),
        .high_source_strength(high_source_strength),
        .high_sink_strength(high_sink_strength),
        .low_source_strength(low_source_strength),
        .low_sink_strength(low_sink_strength), .fault_out_n(fault_out_n));

    tpgdc_bridge_model u_tpgdc_bridge_model (.clock(clock), .stuck(stuck),
        .high_gate_out(high_gate_out), .low_gate_out(low_gate_out),
        .high_gate_below(high_gate_below), .low_gate_below(low_gate_below));

    always #2 clock = ~clock;

    // ==========================================================
    // closing and timeout
    task automatic test_done;
        if (miscompares == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            test_done;
        end
    end

    // ==========================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [AW-1:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge clock);
        while (hreadyout !== 1'h1)
            @(posedge clock);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clock);
        while (hreadyout !== 1'h1)
            @(posedge clock);
        rd = hrdata;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'h1, a, d, x);
    endtask

    task automatic rdchk(input logic [AW-1:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'h0, a, 32'h0, x);
        check(x, e);
    endtask

    function automatic logic sig(input int k);
        case (k)
            0: sig = high_gate_out[0];
            1: sig = high_peak[0];
            default: sig = low_gate_out[0];
        endcase
    endfunction

    // counts falling edges until the watched output reaches lvl
    task automatic wait_for(input int k, input logic lvl);
        n = 0;
        while (sig(k) !== lvl && n < 1200)
        begin
            @(negedge clock);
            n++;
        end
    endtask

    task automatic drive(input int z, input logic v);
        @(posedge clock);
        control_input_n[z] <= v;
    endtask

    function automatic int dead(input int i);
        dead = (DT_NS[i] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
    endfunction

    // ==========================================================
    // main sequence
    initial
    begin
        rstn = 1'h0;
        ce = 1'h1;
        operating_mode = 1'h1;
        enable_in = 1'h1;
        fault_in = 1'h0;
        stuck = 1'h0;
        control_input_n = '0;
        hsel = 1'h0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = '0;
        repeat (16) @(posedge clock);
        rstn <= 1'h1;
        rdchk(REG_CTRL, 32'h0);
        rdchk(REG_SEL, {14'h0, SEL_RST});
        rdchk(8'h10, 32'h0);
        wr(REG_DRIVE, 32'h5F);
        repeat (2) @(negedge clock);
        check({high_source_strength, low_source_strength}, 32'hF5);
        check({high_sink_strength, low_sink_strength}, 32'h3CA);
        // adaptive off: every dead and transition setting in turn
        for (int i = 0; i < 4; i++)
        begin
            wr(REG_CTRL, {26'h0, i[1:0], i[1:0], 2'h2});
            drive(0, 1'h1);
            wait_for(0, 1'h1);
            check(n, dead(i));
            check({high_peak[0], low_strong_sink[0]}, 32'h3);
            wait_for(1, 1'h0);
            check(n, GT_NS[i] / CLK_PERIOD_NS);
            check({high_hold_pullup[0], low_strong_sink[0]}, 32'h2);
            drive(0, 1'h0);
            wait_for(0, 1'h0);
            wait_for(1, 1'h0);
            check(n, GT_NS[i] / CLK_PERIOD_NS);
        end
        // both truth tables; gaps exceed the gate discharge time
        for (int m = 0; m < 2; m++)
        begin
            wr(REG_CTRL, {30'h0, 1'h1, m[0]});
            for (int c = 0; c < 4; c++)
            begin
                @(posedge clock);
                control_input_n[1:0] <= 2'h0;
                repeat (5) @(posedge clock);
                control_input_n[1:0] <= c[1:0];
                repeat (20) @(negedge clock);
                check({high_gate_out[0], low_gate_out[0]},
                    {30'h0, c[0] & (c[1] == m[0]), c[1] & ~c[0]});
                if (c == 2)
                    check({low_peak[0], high_strong_sink[0],
                        low_hold_pullup[0]}, 32'h6);
            end
        end
        // adaptive on: a silent comparator holds off the turn-on; adaptive off: it does not
        wr(REG_CTRL, 32'h0);
        @(posedge clock);
        control_input_n[1:0] <= 2'h0;
        stuck <= 1'h1;
        drive(0, 1'h1);
        repeat (40) @(negedge clock);
        check(high_gate_out[0], 1'h0);
        @(posedge clock);
        stuck <= 1'h0;
        wait_for(0, 1'h1);
        check(n, dead(0));
        wait_for(1, 1'h0);
        drive(0, 1'h0);
        wait_for(0, 1'h0);
        wait_for(1, 1'h0);
        check(32'(n < 8), 32'h1);
        wr(REG_CTRL, 32'h2);
        @(posedge clock);
        stuck <= 1'h1;
        drive(0, 1'h1);
        wait_for(0, 1'h1);
        check(n, dead(0));
        drive(0, 1'h0);
        stuck <= 1'h0;
        // every control input reaches the high gate of phase A
        for (int z = 0; z < NIN; z++)
        begin
            wr(REG_SEL, {14'h0, 15'h7FFF, z[2:0]});
            drive(z, 1'h1);
            wait_for(0, 1'h1);
            rdchk(REG_STATUS, 32'h201);
            drive(z, 1'h0);
            wait_for(0, 1'h0);
        end
        wr(REG_SEL, {14'h0, SEL_RST});
        drive(0, 1'h1);
        wait_for(0, 1'h1);
        @(posedge clock);
        ce <= 1'h0;
        operating_mode <= 1'h0;
        repeat (20) @(negedge clock);
        check(high_gate_out[0], 1'h1);
        @(posedge clock);
        ce <= 1'h1;
        repeat (20) @(negedge clock);
        check({high_gate_out, low_gate_out}, 32'h0);
        @(posedge clock);
        operating_mode <= 1'h1;
        // fault latch released once by clear bit, once by enable pulse
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clock);
            fault_in <= 1'h1;
            @(posedge clock);
            fault_in <= 1'h0;
            repeat (3) @(negedge clock);
            check({hresp, high_hold_pulldown, low_hold_pulldown,
                fault_out_n, gate_hiz_pulldown, high_gate_out,
                low_gate_out}, 32'h40);
            if (k == 0)
                wr(REG_CTRL, 32'h102);
            else
            begin
                @(posedge clock);
                enable_in <= 1'h0;
                @(posedge clock);
                enable_in <= 1'h1;
            end
            @(negedge clock);
            check({fault_out_n, gate_hiz_pulldown}, 32'h2);
            wait_for(0, 1'h1);
            check(high_gate_out[0], 1'h1);
        end
        test_done;
    end
endmodule
